// ===== inc/flc_pkg.sv
`default_nettype none
package flc_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [9:0] IDX_E1_RX_CFG   = 10'h001;
    localparam logic [9:0] IDX_E1_TX_CFG   = 10'h002;
    localparam logic [9:0] IDX_T1_RX_CFG   = 10'h003;
    localparam logic [9:0] IDX_T1_TX_CFG   = 10'h004;
    localparam logic [9:0] IDX_E1_SRC_A    = 10'h005;
    localparam logic [9:0] IDX_E1_SRC_B    = 10'h006;
    localparam logic [9:0] IDX_E1_DIAG     = 10'h007;
    localparam logic [9:0] IDX_T1_SRC_A    = 10'h008;
    localparam logic [9:0] IDX_T1_SRC_B    = 10'h009;
    localparam logic [9:0] IDX_T1_DIAG     = 10'h00A;
    localparam logic [9:0] IDX_E1_RESET    = 10'h00A;
    localparam logic [9:0] IDX_E1_SUMMARY  = 10'h00B;
    localparam logic [9:0] IDX_E1_ACTIVITY = 10'h00D;
    localparam logic [9:0] IDX_T1_RESET    = 10'h00D;
    localparam logic [9:0] IDX_T1_SUMMARY  = 10'h00E;
    localparam logic [9:0] IDX_T1_ACTIVITY = 10'h027;
    localparam logic [9:0] IDX_T1_PCC_CFG  = 10'h030;
    localparam logic [9:0] IDX_MODE        = 10'h03E;
    localparam logic [9:0] IDX_LOOP_MASK0  = 10'h040;
    localparam logic [9:0] IDX_E1_PCC_CFG  = 10'h060;

    // Field positions.
    localparam int RX_EDGE_E1_BIT   = 7;
    localparam int RX_EDGE_T1_BIT   = 2;
    localparam int TX_EDGE_BIT      = 0;
    localparam int ALL_ONES_BIT     = 6;
    localparam int ALL_ZEROS_BIT    = 0;
    localparam int DIGITAL_LOOP_BIT = 2;
    localparam int LINE_LOOP_BIT    = 4;
    localparam int PCC_ENABLE_BIT   = 0;
    localparam int SOFT_RESET_BIT   = 0;
    localparam int MODE_T1_BIT      = 0;
    localparam int MODE_BYPASS_BIT  = 1;

    // Reset values.
    localparam logic [7:0] RST_CFG  = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h01;

    // Pending flags from the per-block interrupt logic.
    typedef struct packed {
        logic       perf_monitor_source;
        logic       frame_generator_source;
        logic       frame_processor_source;
        logic       pattern_gen_detect_source;
        logic       elastic_store_source;
        logic [2:0] rx_hdlc_source;
        logic [2:0] tx_hdlc_source;
        logic       tx_system_if_source;
        logic       tx_jitter_attenuator_source;
        logic       rx_jitter_attenuator_source;
        logic       remote_bit_extractor_source;
        logic       inband_code_detector_source;
        logic       bit_message_rx_source;
        logic       parity_error_source;
        logic       alarm_detector_source;
    } flc_sources_type;

    // Inputs from outside the clock domain, synchronised together.
    typedef struct packed {
        logic line_rx_clock;
        logic line_rx_data;
        logic rx_jitter_attenuator_source_clock;
        logic rx_jitter_attenuator_source_data;
        logic tx_clock_source;
        logic crystal_clock;
        logic tx_common_clock_b;
        logic tx_common_clock_a;
        logic rx_common_clock;
    } flc_pins_type;

endpackage
`default_nettype wire

// ===== hdl/flc_framer_ctrl.sv
// Overview of operation
// - Receive line data sampled on line clock edge chosen by mode-dependent select bit.
// - Transmit line data updated on transmit clock edge chosen by select bit 0.
// - All-ones enable forces continuous ones on transmit data output while transmit disable is clear.
// - Transmit disable bit forces all zeros on transmit data output.
// - Each framer has its own independent transmit clock selection.
// - Active-low interrupt output low while any framer has an enabled pending interrupt.
// - Eight-bit summary register shows one interrupting framer per bit.
// - E1 first source register maps monitor, generator, framer, pattern, store and three receive HDLC bits to bits 7..0.
// - E1 second source register maps transmit interface, jitter, HDLC, remote bits.
// - T1 first source register maps monitor, inband, framer, pattern, store, HDLC, messages.
// - T1 second source register maps HDLC2, parity, jitter, HDLC, remote bits.
// - Each source bit reads one while its block has a pending interrupt.
// - Line loopback routes receive jitter attenuator clock and data, or raw line clock and data in bypass mode, to transmit line.
// - Line loopback still delivers receive data and ignores system transmit data.
// - Digital loopback feeds transmit clock and data into receive inputs.
// - Digital loopback keeps driving line outputs and ignores line receive inputs.
// - Per-channel payload loop bits act only while per-channel enable is one.
// - Payload loop needs aligned receive data; slave modes need identical clocks.
// - Selected transmit slots replaced by received slots; others pass unchanged.
// - Rising edges of five clocks reported in activity bits 4..0.
// - Software reset bit or reset returns framer settings to defaults.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module flc_framer_ctrl #(
    parameter int FRAMER_INDEX = 0,
    parameter int NUM_SLOTS    = 32
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  line_rx_clock,
    input  wire logic                  line_rx_data,
    input  wire logic                  rx_jitter_attenuator_source_clock,
    input  wire logic                  rx_jitter_attenuator_source_data,
    input  wire logic                  tx_clock_source,
    input  wire logic                  crystal_clock,
    input  wire logic                  tx_common_clock_a,
    input  wire logic                  tx_common_clock_b,
    input  wire logic                  rx_common_clock,
    output logic                       line_tx_clock,
    output logic                       line_tx_data,
    input  wire logic                  sys_tx_data,
    input  wire logic [4:0]            tx_slot,
    input  wire logic                  rx_payload_data,
    output logic                       rx_sys_data,
    output logic                       rx_sys_valid,
    input  wire flc_pkg::flc_sources_type block_irq,
    input  wire logic [7:0]            peer_irq_pending,
    output logic                       framer_irq_pending,
    output logic                       irq_n
);

    // Mapping of the block flags into the first source register.
    function automatic logic [7:0] map_src_a(input logic t1, input flc_pkg::flc_sources_type s);
        if (t1) begin
            map_src_a = {s.perf_monitor_source, s.inband_code_detector_source, s.frame_processor_source,
                         s.pattern_gen_detect_source, s.elastic_store_source, s.rx_hdlc_source[0],
                         s.bit_message_rx_source, s.alarm_detector_source};
        end else begin
            map_src_a = {s.perf_monitor_source, s.frame_generator_source, s.frame_processor_source,
                         s.pattern_gen_detect_source, s.elastic_store_source, s.rx_hdlc_source[0],
                         s.rx_hdlc_source[1], s.rx_hdlc_source[2]};
        end
    endfunction

    // Mapping of the block flags into the second source register.
    function automatic logic [7:0] map_src_b(input logic t1, input flc_pkg::flc_sources_type s);
        if (t1) begin
            map_src_b = {s.rx_hdlc_source[1], s.parity_error_source, s.tx_jitter_attenuator_source,
                         s.rx_jitter_attenuator_source, s.tx_hdlc_source[0], s.tx_hdlc_source[1],
                         1'b0, s.remote_bit_extractor_source};
        end else begin
            map_src_b = {s.tx_system_if_source, 1'b0, s.tx_jitter_attenuator_source,
                         s.rx_jitter_attenuator_source, s.tx_hdlc_source[0], s.tx_hdlc_source[1],
                         s.tx_hdlc_source[2], s.remote_bit_extractor_source};
        end
    endfunction

    flc_pkg::flc_pins_type pins_raw;
    flc_pkg::flc_pins_type sync1_q;
    flc_pkg::flc_pins_type sync2_q;
    flc_pkg::flc_pins_type prev_q;

    logic [7:0]           rx_cfg_q;
    logic [7:0]           tx_cfg_q;
    logic [7:0]           diag_q;
    logic [7:0]           pcc_q;
    logic [7:0]           reset_q;
    logic [7:0]           mode_q;
    logic [NUM_SLOTS-1:0] loop_mask_q;
    logic [4:0]           activity_q;
    logic [4:0]           activity_d;
    logic                 rx_clk_prev_q;
    logic                 tx_clk_prev_q;
    logic [31:0]          prdata_q;
    logic                 pready_q;
    logic                 pslverr_q;
    logic                 line_tx_clock_q;
    logic                 line_tx_data_q;
    logic                 rx_sys_data_q;
    logic                 rx_sys_valid_q;
    logic                 irq_n_q;
    logic                 own_pending_q;

    assign pins_raw = '{line_rx_clock, line_rx_data, rx_jitter_attenuator_source_clock, rx_jitter_attenuator_source_data, tx_clock_source,
                        crystal_clock, tx_common_clock_b, tx_common_clock_a, rx_common_clock};

    // Two-stage synchronisers; logic reads the second stage and prev_q, its one-cycle-delayed copy.
    always_ff @(posedge clk) begin
        sync1_q <= pins_raw;
        sync2_q <= sync1_q;
        prev_q  <= sync2_q;
    end

    // Mode and loopback controls decoded from the stored settings.
    wire       mode_t1     = mode_q[flc_pkg::MODE_T1_BIT];
    wire       jat_bypass  = mode_q[flc_pkg::MODE_BYPASS_BIT];
    wire       line_loop   = diag_q[flc_pkg::LINE_LOOP_BIT];
    wire       dig_loop    = diag_q[flc_pkg::DIGITAL_LOOP_BIT];
    wire       force_zeros = diag_q[flc_pkg::ALL_ZEROS_BIT];
    wire       force_ones  = tx_cfg_q[flc_pkg::ALL_ONES_BIT];
    wire       rx_fall     = mode_t1 ? rx_cfg_q[flc_pkg::RX_EDGE_T1_BIT] : rx_cfg_q[flc_pkg::RX_EDGE_E1_BIT];
    wire       tx_rise     = tx_cfg_q[flc_pkg::TX_EDGE_BIT];
    wire       soft_reset  = reset_q[flc_pkg::SOFT_RESET_BIT];

    // Receive path: digital loopback replaces the line pins with the transmit outputs.
    wire       rx_clk_int  = dig_loop ? line_tx_clock_q : sync2_q.line_rx_clock;
    wire       rx_data_int = dig_loop ? line_tx_data_q : sync2_q.line_rx_data;
    wire       rx_edge     = rx_fall ? (rx_clk_prev_q & ~rx_clk_int) : (~rx_clk_prev_q & rx_clk_int);

    // Transmit clock source: line loopback takes the receive attenuator output or the raw line.
    wire       loop_clk    = jat_bypass ? sync2_q.line_rx_clock : sync2_q.rx_jitter_attenuator_source_clock;
    wire       loop_data   = jat_bypass ? sync2_q.line_rx_data : sync2_q.rx_jitter_attenuator_source_data;
    wire       out_clk_src = line_loop ? loop_clk : sync2_q.tx_clock_source;
    wire       tx_edge     = tx_rise ? (~tx_clk_prev_q & out_clk_src) : (tx_clk_prev_q & ~out_clk_src);

    // Payload loopback selects the received slot only while per-channel control is enabled.
    wire       pl_sel      = pcc_q[flc_pkg::PCC_ENABLE_BIT] & loop_mask_q[tx_slot];
    wire       pay_data    = pl_sel ? rx_payload_data : sys_tx_data;
    wire       tx_bit      = line_loop ? loop_data : pay_data;
    wire       tx_next     = force_zeros ? 1'b0 : (force_ones ? 1'b1 : tx_bit);

    // Interrupt tree.
    wire [7:0] src_a       = map_src_a(mode_t1, block_irq);
    wire [7:0] src_b       = map_src_b(mode_t1, block_irq);
    wire       own_pending = |src_a | |src_b;
    wire [7:0] summary     = peer_irq_pending | (8'h01 << FRAMER_INDEX);
    wire [7:0] summary_val = own_pending ? summary : (peer_irq_pending & ~(8'h01 << FRAMER_INDEX));

    // Clock activity: rising edges of the monitored clocks.
    wire [4:0] clk_rise    = {sync2_q.crystal_clock, sync2_q.tx_common_clock_b, sync2_q.tx_common_clock_a,
                              sync2_q.rx_common_clock, sync2_q.line_rx_clock} &
                             ~{prev_q.crystal_clock, prev_q.tx_common_clock_b, prev_q.tx_common_clock_a,
                               prev_q.rx_common_clock, prev_q.line_rx_clock};

    // APB decode; an access completes on the edge where pready_q is high.
    wire [9:0] idx         = paddr[11:2];
    wire       access      = psel & penable;
    wire       done        = access & pready_q;
    wire       wr_done     = done & pwrite & pstrb[0];
    wire       loop_hit    = (idx >= flc_pkg::IDX_LOOP_MASK0) && (idx < flc_pkg::IDX_LOOP_MASK0 + 10'(NUM_SLOTS / 8));
    wire [1:0] loop_sel    = 2'(idx - flc_pkg::IDX_LOOP_MASK0);
    wire       hit_rx      = idx == (mode_t1 ? flc_pkg::IDX_T1_RX_CFG : flc_pkg::IDX_E1_RX_CFG);
    wire       hit_tx      = idx == (mode_t1 ? flc_pkg::IDX_T1_TX_CFG : flc_pkg::IDX_E1_TX_CFG);
    wire       hit_src_a   = idx == (mode_t1 ? flc_pkg::IDX_T1_SRC_A : flc_pkg::IDX_E1_SRC_A);
    wire       hit_src_b   = idx == (mode_t1 ? flc_pkg::IDX_T1_SRC_B : flc_pkg::IDX_E1_SRC_B);
    wire       hit_diag    = idx == (mode_t1 ? flc_pkg::IDX_T1_DIAG : flc_pkg::IDX_E1_DIAG);
    wire       hit_reset   = idx == (mode_t1 ? flc_pkg::IDX_T1_RESET : flc_pkg::IDX_E1_RESET);
    wire       hit_summary = idx == (mode_t1 ? flc_pkg::IDX_T1_SUMMARY : flc_pkg::IDX_E1_SUMMARY);
    wire       hit_act     = idx == (mode_t1 ? flc_pkg::IDX_T1_ACTIVITY : flc_pkg::IDX_E1_ACTIVITY);
    wire       hit_pcc     = idx == (mode_t1 ? flc_pkg::IDX_T1_PCC_CFG : flc_pkg::IDX_E1_PCC_CFG);
    wire       hit_mode    = idx == flc_pkg::IDX_MODE;
    wire       mapped      = hit_rx | hit_tx | hit_src_a | hit_src_b | hit_diag | hit_reset | hit_summary |
                             hit_act | hit_pcc | hit_mode | loop_hit;
    wire [7:0] loop_byte   = loop_mask_q[8*loop_sel +: 8];

    // Read multiplexer.
    wire [7:0] rd_byte     = hit_rx ? rx_cfg_q : hit_tx ? tx_cfg_q : hit_src_a ? src_a : hit_src_b ? src_b :
                             hit_diag ? diag_q : hit_reset ? reset_q : hit_summary ? summary_val :
                             hit_act ? {3'b000, activity_q} : hit_pcc ? pcc_q : hit_mode ? mode_q :
                             loop_hit ? loop_byte : 8'h00;

    // Activity bits clear on the edge that captures them for a read, so no edge is lost; a new edge wins.
    assign activity_d = ((access & ~pready_q & ~pwrite & hit_act) ? 5'h00 : activity_q) | clk_rise;

    // Bus slave answer: one wait state, then pready with data or error.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            prdata_q  <= (access & ~pready_q & ~pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
        end
    end

    // Mode register survives the framer software reset.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_q  <= flc_pkg::RST_MODE;
            reset_q <= flc_pkg::RST_CFG;
        end else if (wr_done) begin
            if (hit_mode) begin
                mode_q <= pwdata[7:0];
            end
            if (hit_reset) begin
                reset_q <= pwdata[7:0];
            end
        end
    end

    // Framer settings; the software reset holds them at defaults while set.
    always_ff @(posedge clk) begin
        if (sys_rst || soft_reset) begin
            rx_cfg_q    <= flc_pkg::RST_CFG;
            tx_cfg_q    <= flc_pkg::RST_CFG;
            diag_q      <= flc_pkg::RST_CFG;
            pcc_q       <= flc_pkg::RST_CFG;
            loop_mask_q <= '0;
        end else if (wr_done) begin
            if (hit_rx) begin
                rx_cfg_q <= pwdata[7:0];
            end
            if (hit_tx) begin
                tx_cfg_q <= pwdata[7:0];
            end
            if (hit_diag) begin
                diag_q <= pwdata[7:0];
            end
            if (hit_pcc) begin
                pcc_q <= pwdata[7:0];
            end
            if (loop_hit) begin
                loop_mask_q[8*loop_sel +: 8] <= pwdata[7:0];
            end
        end
    end

    // Line receive and transmit timing.
    always_ff @(posedge clk) begin
        if (sys_rst || soft_reset) begin
            rx_clk_prev_q   <= 1'b0;
            tx_clk_prev_q   <= 1'b0;
            line_tx_clock_q <= 1'b0;
            line_tx_data_q  <= 1'b0;
            rx_sys_data_q   <= 1'b0;
            rx_sys_valid_q  <= 1'b0;
        end else begin
            rx_clk_prev_q   <= rx_clk_int;
            tx_clk_prev_q   <= out_clk_src;
            line_tx_clock_q <= out_clk_src;
            rx_sys_valid_q  <= rx_edge;
            if (rx_edge) begin
                rx_sys_data_q <= rx_data_int;
            end
            if (tx_edge) begin
                line_tx_data_q <= tx_next;
            end
        end
    end

    // Activity and interrupt output.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            activity_q    <= 5'h00;
            irq_n_q       <= 1'b1;
            own_pending_q <= 1'b0;
        end else begin
            activity_q    <= activity_d;
            irq_n_q       <= ~(|summary_val);
            own_pending_q <= own_pending;
        end
    end

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign line_tx_clock      = line_tx_clock_q;
    assign line_tx_data       = line_tx_data_q;
    assign rx_sys_data        = rx_sys_data_q;
    assign rx_sys_valid       = rx_sys_valid_q;
    assign framer_irq_pending = own_pending_q;
    assign irq_n              = irq_n_q;

    // Checks on the block's own outputs, settings and source register.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_zeros_win;
        tx_edge && force_zeros && !soft_reset |=> !line_tx_data_q;
    endproperty
    a_zeros_win: assert property (p_zeros_win) else $error("transmit data not zero under disable");

    property p_ones;
        tx_edge && force_ones && !force_zeros && !soft_reset |=> line_tx_data_q;
    endproperty
    a_ones: assert property (p_ones) else $error("transmit data not one under all-ones force");

    property p_tx_hold;
        !tx_edge && !soft_reset |=> $stable(line_tx_data_q);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit data changed off the active edge");

    property p_rx_sample;
        rx_edge && !soft_reset |=> rx_sys_valid_q && rx_sys_data_q == $past(rx_data_int);
    endproperty
    a_rx_sample: assert property (p_rx_sample) else $error("receive data not sampled on active edge");

    property p_irq;
        (|summary_val) |=> !irq_n_q;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output not asserted");

    property p_activity;
        sync2_q.crystal_clock && !prev_q.crystal_clock |=> activity_q[4];
    endproperty
    a_activity: assert property (p_activity) else $error("crystal clock edge not reported");

    property p_line_loop;
        line_loop && jat_bypass && !soft_reset |=> line_tx_clock_q == $past(sync2_q.line_rx_clock);
    endproperty
    a_line_loop: assert property (p_line_loop) else $error("line clock not looped to transmit");

    property p_digital;
        dig_loop && rx_edge && !soft_reset |=> rx_sys_data_q == $past(line_tx_data_q);
    endproperty
    a_digital: assert property (p_digital) else $error("transmit data not looped to receive");

    property p_payload;
        tx_edge && pl_sel && !line_loop && !force_zeros && !force_ones && !soft_reset
            |=> line_tx_data_q == $past(rx_payload_data);
    endproperty
    a_payload: assert property (p_payload) else $error("selected slot not replaced by received data");

    // Without the per-channel enable the system data goes out whatever the slot mask says.
    property p_pcc_gate;
        tx_edge && !pcc_q[flc_pkg::PCC_ENABLE_BIT] && !line_loop && !force_zeros && !force_ones && !soft_reset
            |=> line_tx_data_q == $past(sys_tx_data);
    endproperty
    a_pcc_gate: assert property (p_pcc_gate) else $error("slot looped without per-channel enable");

    property p_soft_reset;
        soft_reset |=> diag_q == flc_pkg::RST_CFG && tx_cfg_q == flc_pkg::RST_CFG;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("settings not at defaults in software reset");

    property p_src_map;
        !mode_t1 && block_irq.perf_monitor_source |-> src_a[7] ##1 1'b1;
    endproperty
    a_src_map: assert property (p_src_map) else $error("monitor flag missing from source register");

    c_line_loop: cover property (line_loop && tx_edge);
    c_digital: cover property (dig_loop && rx_edge);
    c_payload: cover property (tx_edge && pl_sel);
    c_irq: cover property (irq_n_q ##1 !irq_n_q);
    c_soft_reset: cover property (soft_reset ##1 !soft_reset);

endmodule // flc_framer_ctrl
`default_nettype wire

// ===== sim/flc_liu_model.sv
`timescale 1ns/1ps
`default_nettype none
module flc_liu_model (
    input  wire logic run,
    input  wire logic send_bit,
    input  wire logic launch_rise,
    output logic      line_rx_clock,
    output logic      line_rx_data
);
    // The line clock of 80 ns runs only while a frame is on and stands low otherwise.
    initial begin
        line_rx_clock = 1'b0;
        line_rx_data  = 1'b0;
        #3;
        forever begin
            #40 line_rx_clock = run & ~line_rx_clock;
        end
    end
    // Data moves on the edge opposite to the sampling edge, so it is steady when sampled.
    always @(line_rx_clock) begin
        if (line_rx_clock == launch_rise) begin
            line_rx_data <= send_bit;
        end
    end
endmodule // flc_liu_model
`default_nettype wire

// ===== sim/flc_framer_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flc_framer_ctrl_tb;
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0, send_bit = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, lrc, lrd, ltc, ltd, rxd, rxv, fip, irq_n;
    logic sysd = 1'b0, payd = 1'b1, lrise = 1'b0;
    logic [4:0] slot = 5'h00;
    logic [5:0] cnt = 6'h00;
    logic [7:0] peer = 8'h00, rd;
    flc_pkg::flc_sources_type src = '0;
    int err_count = 0, n_tests = 0;
    // Free-running clock and a counter whose bits act as slow side clocks.
    always #5 clk = ~clk;
    always @(posedge clk) cnt <= cnt + 6'h01;
    flc_liu_model liu (.run(run), .send_bit(send_bit), .launch_rise(lrise),
        .line_rx_clock(lrc), .line_rx_data(lrd));
    flc_framer_ctrl uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_rx_clock(lrc), .line_rx_data(lrd), .rx_jitter_attenuator_source_clock(cnt[3]), .rx_jitter_attenuator_source_data(cnt[5]),
        .tx_clock_source(cnt[2]), .crystal_clock(cnt[3]), .tx_common_clock_a(cnt[3]),
        .tx_common_clock_b(cnt[4]), .rx_common_clock(cnt[4]), .line_tx_clock(ltc), .line_tx_data(ltd),
        .sys_tx_data(sysd), .tx_slot(slot), .rx_payload_data(payd), .rx_sys_data(rxd),
        .rx_sys_valid(rxv), .block_irq(src), .peer_irq_pending(peer), .framer_irq_pending(fip), .irq_n(irq_n));
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    // One APB transfer: setup, access held until pready is sampled high.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic er);
        int n;
        @(posedge clk);
        psel <= 1'b1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            test_done();
        end
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
        logic er;
        apb(1'b1, idx, wd, er);
    endtask
    task automatic rdc(input string nm, input logic [9:0] idx, input logic [7:0] e);
        logic er;
        apb(1'b0, idx, 8'h00, er);
        chk(nm, e, rd);
        chk({nm, "_err"}, 8'h00, {7'h0, er});
    endtask
    // Counts the cycles of 16 on which the transmit data equals v, and those with the transmit clock high.
    task automatic txhold(input string nm, input logic v);
        int k;
        logic [7:0] m;
        logic [7:0] c;
        repeat (40) @(posedge clk);
        m = 8'h00;
        c = 8'h00;
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            m = m + {7'h0, ltd === v};
            c = c + {7'h0, ltc === 1'b1};
        end
        chk(nm, 8'h10, m);
        chk({nm, "_clk"}, 8'h08, c);
    endtask
    task automatic rxbit(input string nm, input logic v);
        int n;
        repeat (4) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (rxv !== 1'b1 && n < 100);
            chk({nm, "_valid"}, 8'h01, {7'h0, rxv});
            if (rxv !== 1'b1) test_done();
        end
        chk(nm, {7'h0, v}, {7'h0, rxd});
    endtask
    // Main sequence.
    initial begin
        logic er;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        run <= 1'b1;
        rdc("mode", flc_pkg::IDX_MODE, flc_pkg::RST_MODE);
        rdc("t1_tx_cfg", flc_pkg::IDX_T1_TX_CFG, 8'h00);
        apb(1'b0, flc_pkg::IDX_E1_SUMMARY, 8'h00, er);
        chk("other_mode_err", 8'h01, {7'h0, er});
        wr(flc_pkg::IDX_T1_SRC_A, 8'hFF);
        rdc("ro_src_a", flc_pkg::IDX_T1_SRC_A, 8'h00);
        src.perf_monitor_source <= 1'b1; src.parity_error_source <= 1'b1; src.alarm_detector_source <= 1'b1;
        peer <= 8'h08;
        rdc("summary", flc_pkg::IDX_T1_SUMMARY, 8'h09);
        rdc("src_a", flc_pkg::IDX_T1_SRC_A, 8'h81);
        rdc("src_b", flc_pkg::IDX_T1_SRC_B, 8'h40);
        chk("irq_n_low", 8'h00, {7'h0, irq_n});
        chk("own_pending", 8'h01, {7'h0, fip});
        src <= '0;
        peer <= 8'h00;
        repeat (4) @(posedge clk);
        chk("irq_n_high", 8'h01, {7'h0, irq_n});
        chk("own_clear", 8'h00, {7'h0, fip});
        rdc("activity", flc_pkg::IDX_T1_ACTIVITY, 8'h1F);
        rxbit("rx_zero", 1'b0);
        wr(flc_pkg::IDX_T1_TX_CFG, 8'h41);
        txhold("all_ones", 1'b1);
        wr(flc_pkg::IDX_T1_DIAG, 8'h01);
        txhold("zeros_win", 1'b0);
        wr(flc_pkg::IDX_T1_DIAG, 8'h04);
        rxbit("digital_loop", 1'b1);
        txhold("loop_tx_kept", 1'b1);
        wr(flc_pkg::IDX_T1_DIAG, 8'h00);
        wr(flc_pkg::IDX_T1_RX_CFG, 8'h04);
        send_bit <= 1'b1;
        lrise <= 1'b1;
        rxbit("rx_falling", 1'b1);
        // Payload loopback on slot 9 only: system data low, received data high.
        wr(flc_pkg::IDX_T1_TX_CFG, 8'h01);
        wr(flc_pkg::IDX_LOOP_MASK0 + 10'h001, 8'h02);
        slot <= 5'h09;
        txhold("pcc_off", 1'b0);
        wr(flc_pkg::IDX_T1_PCC_CFG, 8'h01);
        txhold("payload_sel", 1'b1);
        slot <= 5'h08;
        txhold("payload_unsel", 1'b0);
        // Line loopback with the attenuator bypassed, then the framer software reset.
        wr(flc_pkg::IDX_MODE, 8'h03);
        wr(flc_pkg::IDX_T1_DIAG, 8'h10);
        txhold("line_loop", 1'b1);
        rxbit("line_loop_rx", 1'b1);
        wr(flc_pkg::IDX_T1_RESET, 8'h01);
        rdc("soft_diag", flc_pkg::IDX_T1_DIAG, 8'h00);
        rdc("soft_mode", flc_pkg::IDX_MODE, 8'h03);
        wr(flc_pkg::IDX_T1_RESET, 8'h00);
        // E1 map and source bit order.
        wr(flc_pkg::IDX_MODE, 8'h00);
        src.frame_generator_source <= 1'b1; src.rx_hdlc_source <= 3'b001;
        src.tx_system_if_source <= 1'b1; src.tx_hdlc_source <= 3'b100;
        rdc("e1_src_a", flc_pkg::IDX_E1_SRC_A, 8'h44);
        rdc("e1_src_b", flc_pkg::IDX_E1_SRC_B, 8'h82);
        rdc("e1_summary", flc_pkg::IDX_E1_SUMMARY, 8'h01);
        test_done();
    end
endmodule // flc_framer_ctrl_tb
`default_nettype wire
